// File: hw/sar_adc_consts.vh
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH
// clock period of clk in ns
`define CLK_PERIOD_NS 4
// conversion time in ns, longest
`define CONV_TIME_NS 2500
// conversion time in clk cycles, rounded down
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
// result width
`define RESULT_BITS 16
// half width used for byte swapping
`define HALF_BITS 8
// result msb position
`define RESULT_MSB 15
// serial pin positions on the result bus
`define SER_IN_POS 9
`define SER_OUT_POS 10
`define SER_CLK_POS 11
// reset value of the held result
`define RESULT_RESET 16'h0000
// bit counter width for serial shifting
`define SHIFT_CNT_BITS 5
`endif

// File: hw/result_buffer.v
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module result_buffer #(
   parameter WIDTH = 16,
   parameter DEPTH = 2,
   parameter AW = 1
) (
   input wire clk,
   input wire rstSync_n,
   input wire flush,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output reg [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr;
   reg [AW-1:0] rdPtr;
   reg [AW:0] count;
   wire doWrite;
   wire doRead;
   integer i;
   assign inReady = (count != DEPTH[AW:0]);
   assign outValid = (count != {(AW+1){1'b0}});
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;
   always @* begin
      outData = mem[rdPtr];
   end
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= {WIDTH{1'b0}};
         end
      end else if (flush) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (doWrite) begin
            mem[wrPtr] <= inData;
            wrPtr <= wrPtr + 1'b1;
         end
         if (doRead) begin
            rdPtr <= rdPtr + 1'b1;
         end
         if (doWrite && !doRead) begin
            count <= count + 1'b1;
         end else if (doRead && !doWrite) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// File: hw/sar_adc_digital_interface.v
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
// Functional notes
// - interface_select high picks serial port, low picks parallel bus.
// - serial mode leaves all unused data lines undriven.
// - format_select low inverts msb for two's complement, both ports.
// - byte_order_select high swaps upper and lower bytes on the parallel data lines; serial output is never swapped.
// - parallel mode drives sixteen lines with result bits 0 to 15.
// - serial mode uses three data lines as serial in, out and clock.
// - serial output sends msb first, one bit per shift clock rise.
// - serial input level reaches serial output sixteen clocks after read start.
// - busy rises at conversion start, stays high until it completes.
// - output drivers enabled only while chip select and read both low.
// - shift clock ignored unless chip select low.
// - reset high holds reset, aborts conversion, floats data bus.
// - power down high ignores conversion start requests.
// - convert start falling edge holds sample and starts conversion.
// - convert start works regardless of chip select.
// - conversion end forms sixteen bit result for either transfer.
module sar_adc_digital_interface #(
   parameter CONV_CYCLES = `CONV_CYCLES
) (
   input wire clk,
   input wire rst_n,
   input wire deviceReset,
   input wire powerDown,
   input wire convertStart_n,
   input wire interfaceSelect,
   input wire formatSelect,
   input wire byteOrderSelect,
   input wire chipSelect_n,
   input wire readEnable_n,
   input wire [`RESULT_BITS-1:0] resultBusIn,
   output reg [`RESULT_BITS-1:0] resultBusOut,
   output reg [`RESULT_BITS-1:0] resultBusOe,
   input wire [`RESULT_BITS-1:0] sarCode,
   input wire sarValid,
   output wire sarReady,
   output reg sampleHold,
   output reg busy
);
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;
   localparam CW = 12;

   reg rstMeta;
   reg rstSync_n;
   reg [1:0] cnvSync;
   reg cnvPrev;
   reg [1:0] csSync;
   reg [1:0] rdSync;
   reg [1:0] sclkSync;
   reg [1:0] sdinSync;
   reg [1:0] resetSync;
   reg [1:0] pdSync;
   reg sclkPrev;
   reg readPrev;
   reg state;
   reg [CW-1:0] convCount;
   reg [`RESULT_BITS-1:0] heldResult;
   reg [`RESULT_BITS-1:0] shiftReg;
   reg [`SHIFT_CNT_BITS-1:0] shiftCount;
   reg serialOut;
   reg busFloat;
   reg [`RESULT_BITS-1:0] next_out;
   reg [`RESULT_BITS-1:0] next_oe;
   wire cnvFall;
   wire sclkRise;
   wire csActive;
   wire readActive;
   wire inReset;
   wire convDone;
   wire bufValid;
   wire bufReady;
   wire [`RESULT_BITS-1:0] bufData;
   wire [`RESULT_BITS-1:0] formatted;
   wire [`RESULT_BITS-1:0] swapped;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync_n <= rstMeta;
      end
   end

   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cnvSync <= 2'h3;
         csSync <= 2'h3;
         rdSync <= 2'h3;
         sclkSync <= 2'h0;
         sdinSync <= 2'h0;
         resetSync <= 2'h0;
         pdSync <= 2'h0;
      end else begin
         cnvSync <= {cnvSync[0], convertStart_n};
         csSync <= {csSync[0], chipSelect_n};
         rdSync <= {rdSync[0], readEnable_n};
         sclkSync <= {sclkSync[0], resultBusIn[`SER_CLK_POS]};
         sdinSync <= {sdinSync[0], resultBusIn[`SER_IN_POS]};
         resetSync <= {resetSync[0], deviceReset};
         pdSync <= {pdSync[0], powerDown};
      end
   end

   assign inReset = resetSync[1];
   assign csActive = !csSync[1];
   assign readActive = csActive && !rdSync[1];
   assign cnvFall = cnvPrev && !cnvSync[1];
   assign sclkRise = !sclkPrev && sclkSync[1] && csActive;
   assign convDone = (state == ST_CONV) && (convCount == CONV_CYCLES[CW-1:0]);
   assign sarReady = convDone;

   // conversion sequencer, chip select plays no part here
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state <= ST_IDLE;
         convCount <= {CW{1'b0}};
         busy <= 1'b0;
         sampleHold <= 1'b0;
         cnvPrev <= 1'b1;
         sclkPrev <= 1'b0;
         readPrev <= 1'b0;
         heldResult <= `RESULT_RESET;
      end else begin
         cnvPrev <= cnvSync[1];
         sclkPrev <= sclkSync[1];
         readPrev <= readActive;
         if (inReset) begin
            state <= ST_IDLE;
            convCount <= {CW{1'b0}};
            busy <= 1'b0;
            sampleHold <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (cnvFall && !pdSync[1]) begin
                     state <= ST_CONV;
                     sampleHold <= 1'b1;
                     busy <= 1'b1;
                     convCount <= {CW{1'b0}};
                  end
               end
               ST_CONV: begin
                  if (convDone) begin
                     state <= ST_IDLE;
                     busy <= 1'b0;
                     sampleHold <= 1'b0;
                     heldResult <= sarCode;
                  end else begin
                     convCount <= convCount + 1'b1;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // up to two finished words queue for either port; a word finishing while two are unread is dropped
   result_buffer #(
      .WIDTH(`RESULT_BITS),
      .DEPTH(2),
      .AW(1)
   ) u_buffer (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .flush(inReset),
      .inValid(convDone && sarValid),
      .inReady(),
      .inData(sarCode),
      .outValid(bufValid),
      .outReady(bufReady),
      .outData(bufData)
   );

   assign formatted = {bufValid ? bufData[`RESULT_MSB] : heldResult[`RESULT_MSB],
      bufValid ? bufData[`RESULT_MSB-1:0] : heldResult[`RESULT_MSB-1:0]} ^
      {!formatSelect, {(`RESULT_BITS-1){1'b0}}};
   assign swapped = byteOrderSelect ?
      {formatted[`HALF_BITS-1:0], formatted[`RESULT_BITS-1:`HALF_BITS]} : formatted;
   // a word is consumed when a serial read starts or a parallel read ends
   assign bufReady = bufValid && (interfaceSelect ?
      (readActive && (shiftCount == {`SHIFT_CNT_BITS{1'b0}}) && sclkRise) : (readPrev && !readActive));

   // serial shifter: daisy chain data follows the sixteen result bits
   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         shiftReg <= `RESULT_RESET;
         shiftCount <= {`SHIFT_CNT_BITS{1'b0}};
         serialOut <= 1'b0;
      end else if (inReset || !csActive) begin
         shiftCount <= {`SHIFT_CNT_BITS{1'b0}};
         shiftReg <= formatted;
         serialOut <= formatted[`RESULT_MSB];
      end else if (shiftCount == {`SHIFT_CNT_BITS{1'b0}} && !sclkRise) begin
         shiftReg <= formatted;
         serialOut <= formatted[`RESULT_MSB];
      end else if (sclkRise) begin
         shiftReg <= {shiftReg[`RESULT_MSB-1:0], sdinSync[1]};
         serialOut <= shiftReg[`RESULT_MSB-1];
         if (shiftCount != {`SHIFT_CNT_BITS{1'b1}}) begin
            shiftCount <= shiftCount + 1'b1;
         end
      end
   end

   always @* begin
      next_out = {`RESULT_BITS{1'b0}};
      next_oe = {`RESULT_BITS{1'b0}};
      if (readActive && !busFloat) begin
         if (interfaceSelect) begin
            next_out[`SER_OUT_POS] = serialOut;
            next_oe[`SER_OUT_POS] = 1'b1;
         end else begin
            next_out = swapped;
            next_oe = {`RESULT_BITS{1'b1}};
         end
      end
   end

   always @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         resultBusOut <= {`RESULT_BITS{1'b0}};
         resultBusOe <= {`RESULT_BITS{1'b0}};
         busFloat <= 1'b0;
      end else begin
         if (inReset && state == ST_CONV) begin
            busFloat <= 1'b1;
         end else if (convDone) begin
            busFloat <= 1'b0;
         end
         resultBusOut <= inReset ? {`RESULT_BITS{1'b0}} : next_out;
         resultBusOe <= inReset ? {`RESULT_BITS{1'b0}} : next_oe;
      end
   end
endmodule

// File: sim/sar_adc_props.sv
`timescale 1ns/1ps
module sar_adc_props #(
   parameter CONV_CYCLES = 625
) (
   input wire clk,
   input wire rst_n,
   input wire deviceReset,
   input wire powerDown,
   input wire convertStart_n,
   input wire interfaceSelect,
   input wire chipSelect_n,
   input wire readEnable_n,
   input wire [15:0] resultBusOe,
   input wire sarReady,
   input wire sampleHold,
   input wire busy
);
   int run;
   logic hit;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // length of the busy run, and whether a device reset cut it short
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run <= 0;
         hit <= 1'b0;
      end else begin
         run <= busy ? run + 1 : 0;
         hit <= busy && (hit || deviceReset);
      end
   end
   a_oe_needs_select: assert property ((chipSelect_n || readEnable_n) [*6] |-> resultBusOe == 16'h0000)
      else $error("bus driven while deselected");
   a_serial_lines_float: assert property (interfaceSelect |-> (resultBusOe & 16'hFBFF) == 16'h0000)
      else $error("unused line driven in serial mode");
   a_parallel_all_lines: assert property (!interfaceSelect && resultBusOe != 16'h0000 |-> resultBusOe == 16'hFFFF)
      else $error("partial parallel drive");
   a_start_raises_busy: assert property ($fell(convertStart_n) && !busy && !powerDown && !deviceReset
      |-> ##[3:5] busy)
      else $error("busy missing after start");
   a_busy_run_length: assert property ($fell(busy) && !hit |-> run >= CONV_CYCLES && run <= CONV_CYCLES + 2)
      else $error("conversion length wrong");
   a_ready_ends_busy: assert property (sarReady |-> ##[0:1] $fell(busy))
      else $error("completion without busy fall");
   a_hold_with_busy: assert property ($rose(busy) |-> sampleHold)
      else $error("not holding during conversion");
   a_powerdown_ignores: assert property (powerDown [*8] ##0 !busy |=> !busy)
      else $error("conversion started while powered down");
   a_reset_floats_bus: assert property (deviceReset [*4] |-> resultBusOe == 16'h0000 && !busy)
      else $error("reset did not abort");
endmodule
bind sar_adc_digital_interface sar_adc_props #(.CONV_CYCLES(CONV_CYCLES)) sar_adc_props_i (
   .clk(clk), .rst_n(rst_n), .deviceReset(deviceReset), .powerDown(powerDown),
   .convertStart_n(convertStart_n), .interfaceSelect(interfaceSelect), .chipSelect_n(chipSelect_n),
   .readEnable_n(readEnable_n), .resultBusOe(resultBusOe), .sarReady(sarReady),
   .sampleHold(sampleHold), .busy(busy)
);

// File: sim/host_reader.sv
`timescale 1ns/1ps
module host_reader (
   output logic sclk,
   output logic chainIn,
   input wire logic result_serial_out
);
   logic [16:0] got;
   initial begin
      sclk = 1'b0;
      chainIn = 1'b1;
      got = 17'h00000;
   end
   // shift clock runs only inside a frame and idles low
   task automatic frame(input int n);
      #2;
      // the msb already stands on the line before the first rise
      got = {got[15:0], result_serial_out};
      repeat (n) begin
         sclk = 1'b1;
         #20;
         sclk = 1'b0;
         got = {got[15:0], result_serial_out};
         #12;
      end
   endtask
endmodule

// File: sim/test_sar_adc_digital_interface.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_sar_adc_digital_interface;
   logic clk, rst_n, deviceReset, powerDown, convertStart_n, interfaceSelect, formatSelect, byteOrderSelect;
   logic chipSelect_n, readEnable_n, tog;
   logic [15:0] sarCode, lf;
   wire [15:0] resultBusIn, resultBusOut, resultBusOe;
   wire sarReady, sampleHold, busy, sclk, chainIn;
   logic [15:0] q[$];
   int n_fail = 0, checks = 0, cycles = 0;
   // released lines 0 to 8 and 10 show a changing pattern; lines 12 to 15 read zero
   assign resultBusIn = (resultBusOe & resultBusOut) | (~resultBusOe & {4'h0, sclk, tog, chainIn, {9{tog}}});
   sar_adc_digital_interface #(.CONV_CYCLES(8)) sar_adc_digital_interface_i (
      .clk(clk), .rst_n(rst_n), .deviceReset(deviceReset), .powerDown(powerDown),
      .convertStart_n(convertStart_n), .interfaceSelect(interfaceSelect), .formatSelect(formatSelect),
      .byteOrderSelect(byteOrderSelect), .chipSelect_n(chipSelect_n), .readEnable_n(readEnable_n),
      .resultBusIn(resultBusIn), .resultBusOut(resultBusOut), .resultBusOe(resultBusOe), .sarCode(sarCode),
      .sarValid(1'b1), .sarReady(sarReady), .sampleHold(sampleHold), .busy(busy));
   host_reader host_reader_i (.sclk(sclk), .chainIn(chainIn), .result_serial_out(resultBusIn[10]));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      tog <= ~tog;
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic [15:0] fmtw(input [15:0] c);
      logic [15:0] r;
      r = formatSelect ? c : c ^ 16'h8000;
      fmtw = byteOrderSelect ? {r[7:0], r[15:8]} : r;
   endfunction
   task automatic convert();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      sarCode = lf;
      q.push_back(lf);
      convertStart_n = 1'b0;
      cyc(6);
      convertStart_n = 1'b1;
      `CHK("busy", 1'b1, busy)
      for (int k = 0; k < 50 && busy !== 1'b0; k++) cyc(1);
      `CHK("done", 1'b0, busy)
      cyc(4);
   endtask
   task automatic rdPar();
      logic [15:0] e;
      e = fmtw(q.pop_front());
      {chipSelect_n, readEnable_n} = 2'h0;
      cyc(6);
      `CHK("par", e, resultBusOut)
      `CHK("oe", 16'hFFFF, resultBusOe)
      {chipSelect_n, readEnable_n} = 2'h3;
      cyc(6);
      `CHK("off", 16'h0000, resultBusOe)
   endtask
   task automatic rdSer();
      logic [15:0] e;
      e = fmtw(q.pop_front());
      host_reader_i.chainIn = ~e[0];
      host_reader_i.frame(3);
      {chipSelect_n, readEnable_n} = 2'h0;
      cyc(8);
      host_reader_i.frame(16);
      `CHK("ser", {e, ~e[0]}, host_reader_i.got)
      `CHK("soe", 16'h0400, resultBusOe)
      {chipSelect_n, readEnable_n} = 2'h3;
      cyc(6);
   endtask
   initial begin
      {rst_n, deviceReset, powerDown, interfaceSelect, formatSelect, byteOrderSelect, tog} = 7'h00;
      {convertStart_n, chipSelect_n, readEnable_n} = 3'h7;
      sarCode = 16'h0000;
      lf = 16'h004B;
      cyc(10);
      rst_n = 1'b1;
      cyc(6);
      for (int i = 0; i < 4; i++) begin
         {formatSelect, byteOrderSelect} = i[1:0];
         convert();
         convert();
         rdPar();
         rdPar();
      end
      {interfaceSelect, byteOrderSelect} = 2'h2;
      for (int i = 0; i < 2; i++) begin
         formatSelect = i[0];
         convert();
         rdSer();
      end
      interfaceSelect = 1'b0;
      powerDown = 1'b1; // results drained first
      cyc(6);
      convertStart_n = 1'b0;
      cyc(6);
      convertStart_n = 1'b1;
      cyc(12);
      `CHK("pd", 1'b0, busy)
      powerDown = 1'b0;
      cyc(6);
      convert();
      convertStart_n = 1'b0;
      cyc(6);
      convertStart_n = 1'b1;
      deviceReset = 1'b1;
      cyc(4);
      `CHK("abort", 1'b0, busy)
      deviceReset = 1'b0;
      q.delete();
      cyc(6);
      convert();
      rdPar();
      tally_and_finish();
   end
endmodule
